// File: src/fwp_checker.sv
// Top: APB-accessed write-protect decision logic with sector lock bits
`timescale 1ns/1ps
module fwp_checker
  import fwp_pkg::*;
#(
  parameter int PON_CYCLES = PON_CYC
) (
  input wire logic pclk, // 40 MHz clock
  input wire logic presetn, // Async active-low reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error for unmapped address
  output logic exec_go, // Pulse: checked operation may run
  output logic [SUB_W-1:0] exec_subsector, // Subsector of the last checked operation, accepted or not
  output logic [1:0] exec_op // Kind of the last checked operation, accepted or not
);
  logic [N_SEC-1:0] write_lock;
  logic [N_SEC-1:0] lock_down;
  fwp_range_s range;
  logic wel;
  logic [31:0] pon_cnt;
  logic power_ok;
  fwp_verdict_s verdict;
  logic [N_SEC-1:0] range_mask;
  logic [N_SEC-1:0] target;
  logic wr, rd, mapped;
  logic [SEC_W-1:0] lk_sec;
  logic [ADDR_W-1:0] chk_addr;
  fwp_op_e chk_op;
  logic [3:0] chk_clks;
  logic [SEC_W-1:0] chk_sec;

  assign pready = 1'b1;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  always_comb begin
    unique case (paddr)
      8'(REG_OFF_CTRL), 8'(REG_OFF_LOCK), 8'(REG_OFF_STAT),
      8'(REG_OFF_CHECK), 8'(REG_OFF_ID): mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !mapped;

  fwp_range u_range (
    .range(range),
    .mask(range_mask)
  );

  // Supply-settle timer; nothing modifies before it expires
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pon_cnt <= 32'h0;
      power_ok <= 1'b0;
    end else if (!power_ok) begin
      pon_cnt <= pon_cnt + 32'h1;
      power_ok <= (pon_cnt + 32'h1 >= 32'(PON_CYCLES));
    end
  end

  assign chk_addr = pwdata[CHK_ADDR_LSB +: ADDR_W];
  assign chk_op = fwp_op_e'(pwdata[CHK_OP_LSB +: 2]);
  assign chk_clks = pwdata[CHK_CLKS_LSB +: 4];
  assign chk_sec = chk_addr[SEC_LSB +: SEC_W];
  assign lk_sec = pwdata[LOCK_SEC_LSB +: SEC_W];

  // Bulk erase targets every sector; others hit one sector
  always_comb begin
    if (chk_op == FWP_OP_BULK_ERASE) begin
      target = '1;
    end else begin
      target = '0;
      target[chk_sec] = 1'b1;
    end
  end

  // Clock count low three bits nonzero means a partial byte
  always_comb begin
    verdict.frame_fail = (chk_clks[2:0] != 3'h0);
    verdict.wel_fail = !wel;
    verdict.lock_fail = |(target & write_lock);
    verdict.range_fail = |(target & range_mask);
    verdict.power_fail = !power_ok;
    verdict.accept = !(verdict.frame_fail || verdict.wel_fail || verdict.lock_fail
                       || verdict.range_fail || verdict.power_fail);
  end

  // Control: range code, direction and write enable latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      range <= '0;
      wel <= 1'b0;
    end else if (wr && paddr == 8'(REG_OFF_CTRL)) begin
      range.range_code <= pwdata[CTRL_BP_LSB +: 3];
      range.range_from_bottom <= pwdata[CTRL_TB_BIT];
      wel <= pwdata[CTRL_WEL_BIT] && power_ok;
    end else if (wr && paddr == 8'(REG_OFF_CHECK) && chk_clks[2:0] == 3'h0) begin
      wel <= 1'b0; // Latch is consumed by any whole-byte modify attempt
    end
  end

  // Lock bits: writable only through the lock register path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_lock <= {N_SEC{LOCK_RST[0]}};
      lock_down <= {N_SEC{LOCK_RST[1]}};
    end else if (wr && paddr == 8'(REG_OFF_LOCK) && power_ok && !lock_down[lk_sec]) begin
      write_lock[lk_sec] <= pwdata[LOCK_WL_BIT];
      lock_down[lk_sec] <= pwdata[LOCK_LD_BIT];
    end
  end

  // Result of a check: one-cycle go pulse, registered target
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exec_go <= 1'b0;
      exec_subsector <= '0;
      exec_op <= 2'h0;
    end else begin
      exec_go <= wr && paddr == 8'(REG_OFF_CHECK) && verdict.accept;
      if (wr && paddr == 8'(REG_OFF_CHECK)) begin
        exec_subsector <= chk_addr[SUB_LSB +: SUB_W];
        exec_op <= chk_op;
      end
    end
  end

  logic [5:0] last_verdict;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_verdict <= '0;
    end else if (wr && paddr == 8'(REG_OFF_CHECK)) begin
      last_verdict <= verdict;
    end
  end

  always_comb begin
    prdata = 32'h0;
    if (rd) begin
      unique case (paddr)
        8'(REG_OFF_CTRL): prdata = {27'h0, wel, range.range_from_bottom, range.range_code};
        8'(REG_OFF_LOCK): prdata = {16'h0, 2'h0, lk_sec_rd(paddr), 6'h0,
                                    lock_down[0], write_lock[0]};
        8'(REG_OFF_STAT): prdata = {25'h0, power_ok, last_verdict};
        8'(REG_OFF_CHECK): prdata = {30'h0, exec_op};
        8'(REG_OFF_ID): prdata = ID_VALUE;
        default: prdata = 32'h0;
      endcase
    end
  end

  function automatic logic [5:0] lk_sec_rd(input logic [7:0] a);
    lk_sec_rd = 6'h0;
  endfunction
endmodule

// File: src/fwp_pkg.sv
// Package: constants and carrier types for the flash write-protect checker
package fwp_pkg;
  localparam int ADDR_W = 24;
  localparam int SUB_LSB = 12;
  localparam int SEC_LSB = 16;
  localparam int N_SEC = 64;
  localparam int SEC_W = 6;
  localparam int SUB_W = 10;
  localparam logic [23:0] TOP_ADDR = 24'h3fffff;
  localparam logic [7:0] LOCK_RST = 8'h00;
  // Supply settle time after reset release, in us, and its cycle count at 40 MHz
  localparam int PON_US = 100;
  localparam int CLK_MHZ = 40;
  localparam int PON_CYC = PON_US * CLK_MHZ;
  localparam int REG_OFF_CTRL = 'h00;
  localparam int REG_OFF_LOCK = 'h04;
  localparam int REG_OFF_STAT = 'h08;
  localparam int REG_OFF_CHECK = 'h0c;
  localparam int REG_OFF_ID = 'h10;
  localparam logic [31:0] ID_VALUE = 32'h0000a5c3; // Arbitrary value
  localparam int CTRL_BP_LSB = 0;
  localparam int CTRL_TB_BIT = 3;
  localparam int CTRL_WEL_BIT = 4;
  localparam int LOCK_WL_BIT = 0;
  localparam int LOCK_LD_BIT = 1;
  localparam int LOCK_SEC_LSB = 8;
  localparam int CHK_ADDR_LSB = 0;
  localparam int CHK_OP_LSB = 24;
  localparam int CHK_CLKS_LSB = 28;

  typedef enum logic [1:0] {
    FWP_OP_PROG = 2'h0,
    FWP_OP_SUB_ERASE = 2'h1,
    FWP_OP_SEC_ERASE = 2'h2,
    FWP_OP_BULK_ERASE = 2'h3
  } fwp_op_e;

  typedef struct packed {
    logic [2:0] range_code;
    logic range_from_bottom;
  } fwp_range_s;

  typedef struct packed {
    logic accept;
    logic wel_fail;
    logic frame_fail;
    logic lock_fail;
    logic range_fail;
    logic power_fail;
  } fwp_verdict_s;
endpackage

// File: src/fwp_range.sv
// Range decoder: block-protect code and direction to a protected-sector mask
`timescale 1ns/1ps
module fwp_range
  import fwp_pkg::*;
(
  input wire fwp_range_s range, // Block-protect code and direction
  output logic [N_SEC-1:0] mask // One bit per protected sector
);
  logic [6:0] cnt;
  always_comb begin
    unique case (range.range_code)
      3'h0: cnt = 7'h00;
      3'h7: cnt = 7'h40;
      default: cnt = 7'(7'h01 << (range.range_code - 3'h1));
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < N_SEC; g++) begin : g_sec
      // Bottom counts up from sector 0, top counts down from 63
      assign mask[g] = range.range_from_bottom ? (7'(g) < cnt)
                                               : (7'(N_SEC - 1 - g) < cnt);
    end
  endgenerate
endmodule

// File: bench/fwp_properties.sv
// Port checker for the write-protect block
`timescale 1ns/1ps
module fwp_properties
  import fwp_pkg::*;
#(parameter int PON_CYCLES = PON_CYC) (
  input wire logic pclk, presetn, psel, penable, pwrite, exec_go,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [SUB_W-1:0] exec_subsector,
  input wire logic [1:0] exec_op
);
  int up;
  logic wok;
  wire acc = psel && penable && pwrite;
  wire ckw = acc && paddr == 8'h0c;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) up <= 0;
    else if (up < PON_CYCLES) up <= up + 1;
  // Weaker than the latch: set even before power is good
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) wok <= 1'b0;
    else if (acc && paddr == 8'h00) wok <= pwdata[4];
    else if (ckw && pwdata[30:28] == 3'h0) wok <= 1'b0;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_go_pulse: assert property (exec_go |=> !exec_go) else $error("go long");
  a_go_cause: assert property (exec_go |-> $past(ckw)) else $error("go uncaused");
  a_byte_frame: assert property ($past(ckw) && $past(pwdata[30:28]) != 3'h0 |-> !exec_go)
    else $error("partial ran");
  a_wel_needed: assert property (exec_go |-> $past(wok)) else $error("no wel");
  a_sub_map: assert property (exec_go |-> exec_subsector == $past(pwdata[21:12]))
    else $error("bad sub");
  a_op_kind: assert property (exec_go |-> exec_op == $past(pwdata[25:24])) else $error("op");
  a_sub_hold: assert property (!$past(ckw) |-> $stable(exec_subsector)) else $error("sub");
  a_power_gate: assert property (exec_go |-> up >= PON_CYCLES) else $error("early");
  c_go: cover property (exec_go);
  c_frame: cover property (ckw && pwdata[30:28] != 3'h0);
  c_sub: cover property (exec_go && exec_op == 2'h1);
endmodule

// File: bench/fwp_host.sv
// APB host model issuing protection checks
`timescale 1ns/1ps
module fwp_host (
  input wire logic pclk, // Clock
  output logic psel, penable, pwrite, // Controls
  output logic [7:0] paddr, // Address
  output logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, pslverr // Answer
);
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // Request held until pready; data inverted once released
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {r, e} = {prdata, pslverr};
    {psel, penable, pwdata} <= {2'b00, ~d};
    @(posedge pclk);
  endtask
endmodule

// File: bench/tb.sv
// Bench: protection checks over the register bus
`timescale 1ns/1ps
module tb;
  import fwp_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, pslverr, exec_go, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [SUB_W-1:0] exec_subsector;
  logic [1:0] exec_op;
  int ngo = 0, miscompares = 0, cmp_count = 0;
  fwp_host u_host(.*);
  fwp_checker #(.PON_CYCLES(10)) u_dut(.*);
  initial forever #12.5 pclk = ~pclk;
  always @(posedge pclk) ngo <= ngo + int'(exec_go === 1'b1);
  task cmp(input string nm, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", nm, e, s);
    end
  endtask
  task conclude;
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, rd, er);
  endtask
  task chk(input logic [23:0] a, input logic [1:0] op, input logic [3:0] k, input logic [4:0] c,
    input logic e);
    int n;
    n = ngo;
    wr(8'h00, {27'h0, c});
    wr(8'h0c, {k, 2'h0, op, a});
    // The go pulse reaches the counter one edge after it stands
    repeat (2) @(posedge pclk);
    cmp("accept", 32'(ngo - n), {31'h0, e});
  endtask
  function automatic logic prot(input int c, s);
    int n;
    n = c % 8 == 7 ? 64 : c % 8 == 0 ? 0 : 1 << (c % 8 - 1);
    return c > 7 ? s < n : s >= 64 - n;
  endfunction
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(24'h0, 2'h0, 4'h0, 5'h10, 1'b0);
    repeat (10) @(posedge pclk);
    chk(24'h3ff000, 2'h0, 4'h0, 5'h10, 1'b1);
    cmp("sub", 32'(exec_subsector), 32'h3ff);
    chk(24'h0, 2'h0, 4'h4, 5'h10, 1'b0);
    chk(24'h0, 2'h0, 4'h0, 5'h00, 1'b0);
    $display("test basic done");
    for (int c = 0; c < 16; c++)
      for (int s = 0; s < 64; s++)
        chk({s[5:0], 16'h0}, 2'h2, 4'h0, {1'b1, c[3:0]}, !prot(c, s));
    $display("test range done");
    wr(8'h04, 32'h0501);
    chk(24'h050000, 2'h2, 4'h0, 5'h10, 1'b0);
    chk(24'h0, 2'h3, 4'h0, 5'h10, 1'b0);
    wr(8'h04, 32'h0502);
    wr(8'h04, 32'h0501);
    chk(24'h05f000, 2'h1, 4'h8, 5'h10, 1'b1);
    cmp("op", 32'(exec_op), 32'h1);
    u_host.xfer(1'b0, 8'h40, 32'h0, rd, er);
    cmp("slverr", {31'h0, er}, 32'h1);
    $display("test lock done");
    conclude();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    conclude();
  end
endmodule
bind fwp_checker fwp_properties #(.PON_CYCLES(PON_CYCLES)) u_prop(.*);
